//--- common/sfpe_pkg.sv
// Constants and types shared by the serial flash program and erase engine.
package sfpe_pkg;
	localparam int PC_W = 14;
	localparam int DATA_W = 14;
	localparam int CMD_W = 6;
	localparam int OP_W = 5;
	localparam int LAT_N = 8;
	localparam int LAT_IDX_W = 3;
	localparam int ROW_LSB = 5;
	localparam int CP_BIT = 6;
	localparam int TMR_W = 20;
	// Command codes; the top command bit is a don't care.
	localparam logic [OP_W-1:0] OP_LOAD_CFG = 5'h00;
	localparam logic [OP_W-1:0] OP_LOAD_DATA = 5'h02;
	localparam logic [OP_W-1:0] OP_READ = 5'h04;
	localparam logic [OP_W-1:0] OP_INC_ADDR = 5'h06;
	localparam logic [OP_W-1:0] OP_RESET_ADDR = 5'h16;
	localparam logic [OP_W-1:0] OP_BEGIN_INT = 5'h08;
	localparam logic [OP_W-1:0] OP_BEGIN_EXT = 5'h18;
	localparam logic [OP_W-1:0] OP_END_EXT = 5'h0a;
	localparam logic [OP_W-1:0] OP_BULK_ERASE = 5'h09;
	localparam logic [OP_W-1:0] OP_ROW_ERASE = 5'h11;
	// Serial frame: falling edges counted per command and per data frame.
	localparam logic [4:0] CMD_FALLS = 5'd6;
	localparam logic [4:0] FRAME_FALLS = 5'd16;
	localparam logic [4:0] DATA_FIRST = 5'd1;
	localparam logic [4:0] DATA_LAST = 5'd14;
	// Address map.
	localparam logic [PC_W-1:0] PC_ZERO = 14'h0000;
	localparam logic [PC_W-1:0] CFG_BASE = 14'h2000;
	localparam logic [PC_W-1:0] CFG_LAST = 14'h2008;
	localparam logic [PC_W-1:0] CFG_WORD1 = 14'h2007;
	localparam logic [LAT_IDX_W-1:0] LAT_LAST = 3'h7;
	// Internal timing, in microseconds, and the clock period.
	localparam int CLK_PERIOD_NS = 50;
	localparam int BULK_ERASE_US = 5000;
	localparam int ROW_ERASE_US = 2500;
	localparam int PROG_US = 2500;
	localparam int BULK_ERASE_CYC = (BULK_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_ERASE_CYC = (ROW_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYC = (PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {ST_CMD, ST_LOAD, ST_READ} sfpe_state_t;
endpackage : sfpe_pkg

//--- design/sfpe_engine.sv
// Serial program and erase engine with write latches and code protection.
//
// Behaviour
// - Bulk erase in user range keeps IDs.
// - Bulk erase in config range erases IDs.
// - Bulk erase busy until bulk time elapses.
// - Bulk erase ignores code protection.
// - Row is 32 words, PC bits 13:5.
// - Protected row erase in program memory ignored.
// - Config range row erase erases IDs only.
// - Row erase busy until row time elapses.
// - Eight 14-bit write latches per begin command.
// - Each load fills one latch until begin.
// - Low PC bits pick latch; aligned group.
// - More than eight loads overwrite latches.
// - Protected program memory reads return zeros.
// - Protected program memory refuses programming.
// - IDs and config words always accessible.
// - Zero code-protect bit enables protection.
// - Only bulk erase clears protection.
// - Six-bit commands, LSb first, sample falling.
// - Load configuration sets PC to 2000h.
// - Reset address clears PC to zero.
module sfpe_engine
	import sfpe_pkg::*;
#(
	parameter int BULK_CYC = sfpe_pkg::BULK_ERASE_CYC,
	parameter int ROW_CYC = sfpe_pkg::ROW_ERASE_CYC,
	parameter int PRG_CYC = sfpe_pkg::PROG_CYC
)
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic prog_serial_clock,
	input wire logic prog_serial_data_i,
	output logic prog_serial_data_o,
	output logic prog_serial_data_oe,
	input wire logic code_protect_n,
	output logic [sfpe_pkg::PC_W-1:0] nvm_rd_addr,
	input wire logic [sfpe_pkg::DATA_W-1:0] nvm_rd_data,
	output logic nvm_wr,
	output logic [sfpe_pkg::PC_W-1:0] nvm_wr_addr,
	output logic [sfpe_pkg::DATA_W-1:0] nvm_wr_data,
	output logic nvm_bulk_erase,
	output logic nvm_erase_ids,
	output logic nvm_row_erase,
	output logic [sfpe_pkg::PC_W-ROW_LSB-1:0] nvm_row_addr,
	output logic nvm_id_erase,
	output logic prog_busy,
	output logic code_protect_active
);
	import sfpe_pkg::*;

	// ----------------------------------------------------------------
	// Link sampling
	// ----------------------------------------------------------------
	// Both pins pass two flops so clock and data stay aligned in time.
	logic clk_s1_ff, clk_s2_ff, clk_prev_ff, dat_s1_ff, dat_s2_ff;
	always_ff @(posedge clock)
	begin
		clk_s1_ff <= prog_serial_clock;
		clk_s2_ff <= clk_s1_ff;
		clk_prev_ff <= clk_s2_ff;
		dat_s1_ff <= prog_serial_data_i;
		dat_s2_ff <= dat_s1_ff;
	end

	wire link_fall = clk_prev_ff & ~clk_s2_ff;
	wire link_rise = ~clk_prev_ff & clk_s2_ff;

	// ----------------------------------------------------------------
	// Command and frame state
	// ----------------------------------------------------------------
	sfpe_state_t state_ff, nxt_state;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [CMD_W-1:0] cmd_ff, nxt_cmd;
	logic [DATA_W-1:0] sreg_ff, nxt_sreg;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic cp_ff, cp_seen_ff;
	logic [TMR_W-1:0] tmr_ff, nxt_tmr;
	logic ext_ff, nxt_ext;
	logic wr_run_ff, nxt_wr_run;
	logic [LAT_IDX_W-1:0] wr_idx_ff, nxt_wr_idx;
	logic [LAT_N-1:0] vld_ff;
	logic [DATA_W-1:0] lat_ff [LAT_N];
	logic dout_ff, oe_ff, nxt_dout, nxt_oe;
	logic bulk_ff, ids_ff, row_ff, id_ff;

	// Command decode: the last command fall completes the opcode.
	wire [CMD_W-1:0] cmd_full = {dat_s2_ff, cmd_ff[CMD_W-1:1]};
	wire [OP_W-1:0] op = cmd_full[OP_W-1:0];
	wire cmd_done = (state_ff == ST_CMD) && link_fall && (cnt_ff == CMD_FALLS - 5'd1);
	wire frame_end = (state_ff != ST_CMD) && link_fall && (cnt_ff == FRAME_FALLS - 5'd1);
	wire in_pm = pc_ff < CFG_BASE;
	wire in_cfg = (pc_ff >= CFG_BASE) && (pc_ff <= CFG_LAST);
	wire pm_locked = cp_ff && in_pm;
	wire do_begin = cmd_done && ((op == OP_BEGIN_INT) || (op == OP_BEGIN_EXT));
	wire do_bulk = cmd_done && (op == OP_BULK_ERASE);
	wire do_row = cmd_done && (op == OP_ROW_ERASE);
	wire load_end = frame_end && (state_ff == ST_LOAD);
	wire [DATA_W-1:0] rd_word = pm_locked ? '0 : nvm_rd_data;
	wire tmr_load = do_bulk || (do_row && (in_cfg || !pm_locked))
		|| (do_begin && (op == OP_BEGIN_INT));

	// Next-state logic for the serial side and the program counter.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_cmd = cmd_ff;
		nxt_sreg = sreg_ff;
		nxt_pc = pc_ff;
		nxt_dout = dout_ff;
		nxt_oe = oe_ff;
		unique case (state_ff)
			ST_CMD:
			begin
				if (link_fall)
				begin
					nxt_cmd = cmd_full;
					nxt_cnt = cnt_ff + 5'd1;
				end
				if (cmd_done)
				begin
					nxt_cnt = '0;
					if ((op == OP_LOAD_CFG) || (op == OP_LOAD_DATA))
						nxt_state = ST_LOAD;
					else if (op == OP_READ)
					begin
						nxt_state = ST_READ;
						nxt_sreg = rd_word;
					end
					else if (op == OP_INC_ADDR)
						nxt_pc = pc_ff + 14'h0001;
					else if (op == OP_RESET_ADDR)
						nxt_pc = PC_ZERO;
					// Moving the counter at the command makes the frame fill the base latch.
					if (op == OP_LOAD_CFG)
						nxt_pc = CFG_BASE;
				end
			end
			ST_LOAD:
			begin
				if (link_fall)
				begin
					nxt_cnt = cnt_ff + 5'd1;
					if ((cnt_ff >= DATA_FIRST) && (cnt_ff <= DATA_LAST))
						nxt_sreg = {dat_s2_ff, sreg_ff[DATA_W-1:1]};
				end
				if (frame_end)
				begin
					nxt_state = ST_CMD;
					nxt_cnt = '0;
				end
			end
			ST_READ:
			begin
				// Drive from the first frame fall; shift out on the rises between.
				if (link_fall)
				begin
					nxt_cnt = cnt_ff + 5'd1;
					nxt_oe = 1'b1;
				end
				if (link_rise && (cnt_ff >= DATA_FIRST) && (cnt_ff <= DATA_LAST))
				begin
					nxt_dout = sreg_ff[0];
					nxt_sreg = {1'b0, sreg_ff[DATA_W-1:1]};
				end
				else if (link_rise)
					nxt_dout = 1'b0;
				if (frame_end)
				begin
					nxt_state = ST_CMD;
					nxt_cnt = '0;
					nxt_oe = 1'b0;
					nxt_dout = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_ff <= ST_CMD;
			cnt_ff <= '0;
			cmd_ff <= '0;
			sreg_ff <= '0;
			pc_ff <= PC_ZERO;
			dout_ff <= 1'b0;
			oe_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cmd_ff <= nxt_cmd;
			sreg_ff <= nxt_sreg;
			pc_ff <= nxt_pc;
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
		end
	end

	// ----------------------------------------------------------------
	// Write latches
	// ----------------------------------------------------------------
	// Latches drain on a begin command; a new load wins over the clear.
	wire wr_ok = !pm_locked;
	for (genvar i = 0; i < LAT_N; i++)
	begin : g_lat
		wire hit = load_end && (pc_ff[LAT_IDX_W-1:0] == LAT_IDX_W'(i));
		always_ff @(posedge clock)
		begin
			if (sys_rst)
				vld_ff[i] <= 1'b0;
			else if (hit)
				vld_ff[i] <= 1'b1;
			else if (do_begin)
				vld_ff[i] <= 1'b0;
		end
		always_ff @(posedge clock)
		begin
			if (sys_rst)
				lat_ff[i] <= '0;
			else if (hit)
				lat_ff[i] <= sreg_ff;
		end
	end

	// Copy of the latches taken at begin, so the next loads can start early.
	logic [DATA_W-1:0] wq_ff [LAT_N];
	logic [LAT_N-1:0] wq_vld_ff;
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			wq_vld_ff <= '0;
		else if (do_begin)
			wq_vld_ff <= wr_ok ? vld_ff : '0;
	end
	always_ff @(posedge clock)
	begin
		if (do_begin)
			wq_ff <= lat_ff;
	end

	// Walk the eight aligned words of the group, one per cycle.
	always_comb
	begin
		nxt_wr_run = wr_run_ff;
		nxt_wr_idx = wr_idx_ff;
		if (do_begin)
		begin
			nxt_wr_run = 1'b1;
			nxt_wr_idx = '0;
		end
		else if (wr_run_ff)
		begin
			nxt_wr_idx = wr_idx_ff + 3'h1;
			nxt_wr_run = wr_idx_ff != LAT_LAST;
		end
	end

	assign nvm_wr = wr_run_ff && wq_vld_ff[wr_idx_ff];
	assign nvm_wr_addr = {pc_ff[PC_W-1:LAT_IDX_W], wr_idx_ff};
	assign nvm_wr_data = wq_ff[wr_idx_ff];
	assign nvm_rd_addr = pc_ff;

	// ----------------------------------------------------------------
	// Erase, timing and protection
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_tmr = tmr_ff;
		nxt_ext = ext_ff;
		if (tmr_ff != '0)
			nxt_tmr = tmr_ff - 20'h1;
		if (do_bulk)
			nxt_tmr = TMR_W'(BULK_CYC);
		else if (tmr_load && (op == OP_ROW_ERASE))
			nxt_tmr = TMR_W'(ROW_CYC);
		else if (tmr_load)
			nxt_tmr = TMR_W'(PRG_CYC);
		if (do_begin && (op == OP_BEGIN_EXT))
			nxt_ext = 1'b1;
		else if (cmd_done && (op == OP_END_EXT))
			nxt_ext = 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			tmr_ff <= '0;
			ext_ff <= 1'b0;
			wr_run_ff <= 1'b0;
			wr_idx_ff <= '0;
			bulk_ff <= 1'b0;
			ids_ff <= 1'b0;
			row_ff <= 1'b0;
			id_ff <= 1'b0;
		end
		else
		begin
			tmr_ff <= nxt_tmr;
			ext_ff <= nxt_ext;
			wr_run_ff <= nxt_wr_run;
			wr_idx_ff <= nxt_wr_idx;
			bulk_ff <= do_bulk;
			ids_ff <= do_bulk && in_cfg;
			row_ff <= do_row && in_pm && !cp_ff;
			id_ff <= do_row && in_cfg;
		end
	end

	always_ff @(posedge clock)
	begin
		if (do_row)
			nvm_row_addr <= pc_ff[PC_W-1:ROW_LSB];
	end

	// Protection is caught from the array once after reset, then tracked.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cp_ff <= 1'b0;
			cp_seen_ff <= 1'b0;
		end
		else if (!cp_seen_ff)
		begin
			cp_ff <= !code_protect_n;
			cp_seen_ff <= 1'b1;
		end
		else if (bulk_ff)
			cp_ff <= 1'b0;
		else if (nvm_wr && (nvm_wr_addr == CFG_WORD1) && !nvm_wr_data[CP_BIT])
			cp_ff <= 1'b1;
	end

	assign nvm_bulk_erase = bulk_ff;
	assign nvm_erase_ids = ids_ff;
	assign nvm_row_erase = row_ff;
	assign nvm_id_erase = id_ff;
	assign prog_busy = (tmr_ff != '0) || ext_ff || wr_run_ff;
	assign code_protect_active = cp_ff;
	assign prog_serial_data_o = dout_ff;
	assign prog_serial_data_oe = oe_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_bulk_ids; do_bulk && in_pm |=> nvm_bulk_erase && !nvm_erase_ids; endproperty
	a_bulk_ids: assert property (p_bulk_ids) else $error("ids erased from user range");
	property p_cfg_ids; do_bulk && in_cfg |=> nvm_erase_ids; endproperty
	a_cfg_ids: assert property (p_cfg_ids) else $error("ids kept on config bulk");
	property p_bulk_busy; do_bulk |=> prog_busy [*8]; endproperty
	a_bulk_busy: assert property (p_bulk_busy) else $error("bulk erase ended early");
	property p_cp_clear; nvm_bulk_erase |=> !code_protect_active; endproperty
	a_cp_clear: assert property (p_cp_clear) else $error("bulk left protection");
	property p_row_lock; nvm_row_erase |-> !code_protect_active; endproperty
	a_row_lock: assert property (p_row_lock) else $error("protected row erased");
	property p_row_cfg; do_row && in_cfg |=> nvm_id_erase && !nvm_row_erase; endproperty
	a_row_cfg: assert property (p_row_cfg) else $error("config row erase wrong");
	property p_wr_lock; nvm_wr |-> !(code_protect_active && nvm_wr_addr < CFG_BASE); endproperty
	a_wr_lock: assert property (p_wr_lock) else $error("protected word written");
	property p_rd_zero; cmd_done && op == OP_READ && pm_locked |=> sreg_ff == '0; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("protected read not zero");
	property p_pc_rst; cmd_done && op == OP_RESET_ADDR |=> pc_ff == PC_ZERO; endproperty
	a_pc_rst: assert property (p_pc_rst) else $error("reset address failed");
	property p_pc_cfg; load_end && cmd_ff[OP_W-1:0] == OP_LOAD_CFG |=> pc_ff == CFG_BASE; endproperty
	a_pc_cfg: assert property (p_pc_cfg) else $error("load config pc wrong");
	property p_begin_walk; do_begin |=> wr_run_ff [*8] ##1 !wr_run_ff; endproperty
	a_begin_walk: assert property (p_begin_walk) else $error("latch walk length");

	c_bulk: cover property (do_bulk && in_cfg);
	c_write: cover property (nvm_wr ##1 nvm_wr);
	c_read: cover property (frame_end && state_ff == ST_READ);
	c_ext: cover property (ext_ff ##1 !ext_ff);
endmodule : sfpe_engine

//--- tb/sfpe_programmer.sv
// Behavioural model of the external programmer on the serial clock and data pins.
module sfpe_programmer
(
	input wire logic clock,
	input wire logic line,
	output logic sclk,
	output logic sdat
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Link bit and frame tasks
	// ----------------------------------------------------------------

	// The link clock stands still low between frames.
	initial
	begin
		sclk = 1'b0;
		sdat = 1'b0;
	end

	// Data moves on the rise and is taken just after the fall, while it is still held.
	// A released line shows the inverse of its last value, so a stale bit cannot pass.
	task automatic bit_io(input logic b, input logic drive, output logic seen);
		@(posedge clock);
		sclk <= 1'b1;
		sdat <= drive ? b : ~sdat;
		repeat (4) @(posedge clock);
		sclk <= 1'b0;
		@(posedge clock);
		seen = line;
		repeat (2) @(posedge clock);
	endtask : bit_io

	// Six command bits, least significant first, then the normal gap.
	task automatic send_cmd(input logic [5:0] c);
		logic s;
		for (int i = 0; i < 6; i++)
			bit_io(c[i], 1'b1, s);
		repeat (4) @(posedge clock);
	endtask : send_cmd

	// Sixteen clocks: start bit, fourteen data bits, stop bit.
	task automatic frame(input logic drive, input logic [13:0] d, output logic [13:0] q);
		logic [15:0] o;
		logic [15:0] f;
		o = {1'b0, d, 1'b0};
		for (int i = 0; i < 16; i++)
			bit_io(o[i], drive, f[i]);
		q = f[14:1];
		repeat (4) @(posedge clock);
	endtask : frame
endmodule : sfpe_programmer

//--- tb/sfpe_engine_test.sv
// Self-checking bench for the serial program and erase engine.
module sfpe_engine_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sfpe_pkg::*;

	// ----------------------------------------------------------------
	// Signals, array and reference model
	// ----------------------------------------------------------------
	localparam int T_CYC = 40;
	localparam int DIS_CYC = 40; // Longer than the normal command gap.
	// Used bits of the two configuration words in the checksum.
	localparam logic [DATA_W-1:0] CFG1_MASK = 14'h3f7f;
	localparam logic [DATA_W-1:0] CFG2_MASK = 14'h0030;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic sclk, pdat, line, dat_o, dat_oe, wr, bulk, ids, row, id_er, busy, cp_act;
	logic [PC_W-1:0] rd_addr, wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [PC_W-ROW_LSB-1:0] row_addr;
	logic [DATA_W-1:0] mem [0:16383];
	logic [DATA_W-1:0] exp_mem [0:16383];
	logic [DATA_W-1:0] lat [0:7];
	bit lv [0:7];
	bit prot;
	int pc, fail_count, tests_run;
	logic [31:0] rs = 32'h5c2a;

	initial
	begin
		forever #25 clock = ~clock;
	end

	// The engine wins the data line while it drives it.
	assign line = dat_oe ? dat_o : pdat;

	sfpe_engine #(.BULK_CYC(T_CYC), .ROW_CYC(T_CYC), .PRG_CYC(T_CYC)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .prog_serial_clock(sclk),
		.prog_serial_data_i(line), .prog_serial_data_o(dat_o), .prog_serial_data_oe(dat_oe),
		.code_protect_n(mem[CFG_WORD1][CP_BIT]), .nvm_rd_addr(rd_addr),
		.nvm_rd_data(mem[rd_addr]), .nvm_wr(wr), .nvm_wr_addr(wr_addr), .nvm_wr_data(wr_data),
		.nvm_bulk_erase(bulk), .nvm_erase_ids(ids), .nvm_row_erase(row),
		.nvm_row_addr(row_addr), .nvm_id_erase(id_er), .prog_busy(busy),
		.code_protect_active(cp_act));

	sfpe_programmer i_prog (.clock(clock), .line(line), .sclk(sclk), .sdat(pdat));

	// Array behind the engine; erased words hold all ones. Scans only on a strobe.
	always @(posedge clock)
	begin
		if (wr)
			mem[wr_addr] <= wr_data;
		if (bulk || id_er || row)
			for (int a = 0; a < 16384; a++)
				if ((bulk && (a < 32'h2000 || a == 32'h2007 || a == 32'h2008))
					|| ((bulk && ids || id_er) && a >= 32'h2000 && a < 32'h2004)
					|| (row && a / 32 == row_addr))
					mem[a] <= '1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
		tests_run++;
		if (seen !== want)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// The unused top command bit gets a random value.
	task automatic cmd(input logic [OP_W-1:0] op);
		logic [31:0] r;
		r = rnd();
		i_prog.send_cmd({r[0], op});
	endtask : cmd

	task automatic load(input bit cfg, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		cmd(cfg ? OP_LOAD_CFG : OP_LOAD_DATA);
		i_prog.frame(1'b1, d, q);
		if (cfg)
			pc = 32'h2000;
		lat[pc % 8] = d;
		lv[pc % 8] = 1'b1;
	endtask : load

	task automatic inc(input int n);
		for (int i = 0; i < n; i++)
		begin
			cmd(OP_INC_ADDR);
			pc++;
		end
	endtask : inc

	// Results are only relied on once busy has dropped.
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400)
		begin
			@(posedge clock);
			n++;
		end
		check(14'(n < 400), 14'h0001);
	endtask : wait_idle

	task automatic prog(input bit ext);
		int a;
		cmd(ext ? OP_BEGIN_EXT : OP_BEGIN_INT);
		if (ext)
		begin
			cmd(OP_END_EXT);
			repeat (DIS_CYC) @(posedge clock);
		end
		for (int i = 0; i < 8; i++)
		begin
			a = (pc & ~7) | i;
			if (lv[i] && !(prot && pc < 32'h2000))
			begin
				exp_mem[a] = lat[i];
				prot |= a == 32'h2007 && !lat[i][CP_BIT];
			end
			lv[i] = 1'b0;
		end
		wait_idle();
	endtask : prog

	// Bulk erase is only ever sent with the counter at or below the last config word.
	task automatic erase(input bit bulk_op);
		bit cfg_pc;
		cfg_pc = pc >= 32'h2000 && pc <= 32'h2008;
		cmd(bulk_op ? OP_BULK_ERASE : OP_ROW_ERASE);
		check(14'(busy), 14'(bulk_op || cfg_pc || !prot));
		for (int a = 0; a < 16384; a++)
			if ((bulk_op && (a < 32'h2000 || a == 32'h2007 || a == 32'h2008))
				|| (cfg_pc && a >= 32'h2000 && a < 32'h2004)
				|| (!bulk_op && !cfg_pc && !prot && a / 32 == pc / 32))
				exp_mem[a] = '1;
		if (bulk_op)
			prot = 1'b0;
		wait_idle();
	endtask : erase

	task automatic cmp_range(input int lo, input int hi);
		for (int a = lo; a <= hi; a++)
			check(mem[a], exp_mem[a]);
	endtask : cmp_range

	// Programmer's checksum, summed over the array and over the model alike.
	task automatic csum_check();
		logic [15:0] s_dev;
		logic [15:0] s_exp;
		s_dev = 16'(mem[32'h2007] & CFG1_MASK) + 16'(mem[32'h2008] & CFG2_MASK);
		s_exp = 16'(exp_mem[32'h2007] & CFG1_MASK) + 16'(exp_mem[32'h2008] & CFG2_MASK);
		for (int a = 0; a < 32'h2000; a++)
			if (!prot)
			begin
				s_dev += 16'(mem[a]);
				s_exp += 16'(exp_mem[a]);
			end
		for (int a = 32'h2000; a < 32'h2004; a++)
			if (prot)
			begin
				s_dev += 16'(mem[a] & 14'h000f);
				s_exp += 16'(exp_mem[a] & 14'h000f);
			end
		check(14'(s_dev), 14'(s_exp));
		check(14'(s_dev >> 14), 14'(s_exp >> 14));
	endtask : csum_check

	task automatic rd(input int n);
		logic [DATA_W-1:0] q;
		for (int i = 0; i < n; i++)
		begin
			cmd(OP_READ);
			i_prog.frame(1'b0, 14'h0000, q);
			check(q, (prot && pc < 32'h2000) ? 14'h0000 : exp_mem[pc]);
			if (i < n - 1)
				inc(1);
		end
	endtask : rd

	task automatic rst_addr();
		cmd(OP_RESET_ADDR);
		pc = 0;
		check(rd_addr, PC_ZERO);
	endtask : rst_addr

	// ----------------------------------------------------------------
	// Sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (60000) @(posedge clock);
		fail_count++;
		stop_test();
	end

	initial
	begin
		for (int a = 0; a < 16384; a++)
		begin
			mem[a] = '1;
			exp_mem[a] = '1;
		end
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		check(14'(cp_act), 14'h0000);
		check(14'(busy), 14'h0000);
		// Ten loads wrap the latches; the begin at 9 writes the group 8 to 15.
		for (int i = 0; i < 10; i++)
		begin
			load(1'b0, 14'(rnd()));
			if (i < 9)
				inc(1);
		end
		prog(1'b0);
		rst_addr();
		rd(16);
		csum_check();
		// Externally timed write into row 1, then erase that row.
		inc(19);
		for (int i = 0; i < 8; i++)
		begin
			load(1'b0, 14'(rnd()));
			if (i < 7)
				inc(1);
		end
		prog(1'b1);
		cmp_range(32, 47);
		erase(1'b0);
		check(14'(row_addr), 14'(pc / 32));
		cmp_range(0, 63);
		// User ID and config word 1 with the protect bit low, in one begin.
		load(1'b1, 14'(rnd()));
		inc(7);
		load(1'b0, 14'(rnd()) & ~14'h0040);
		prog(1'b0);
		check(14'(cp_act), 14'h0001);
		rd(1);
		cmp_range(32'h2000, 32'h2008);
		csum_check();
		rst_addr();
		rd(1);
		load(1'b0, 14'(rnd()));
		prog(1'b0);
		erase(1'b0);
		cmp_range(0, 63);
		load(1'b1, 14'(rnd()));
		erase(1'b0);
		prog(1'b0);
		cmp_range(32'h2000, 32'h2008);
		check(14'(cp_act), 14'h0001);
		rst_addr();
		erase(1'b1);
		check(14'(cp_act), 14'h0000);
		cmp_range(0, 63);
		cmp_range(32'h2000, 32'h2008);
		load(1'b1, 14'(rnd()));
		erase(1'b1);
		cmp_range(32'h2000, 32'h2008);
		stop_test();
	end
endmodule : sfpe_engine_test
